/* File: pkg/tmr_defines.vh */
// Constants for the dual timer block: register offsets, fields, counts.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
// Notes on behaviour
// - Internal counting advances once per machine cycle, every two clocks.
// - Timer 0 may count falling edges of the external count input.
// - Mode 0 is an 8-bit counter behind a divide-by-32 prescaler.
// - Mode 1 chains low and high byte into one 16-bit counter.
// - Mode 2 counts the low byte and reloads it from the high byte.
// - Mode 3 splits timer 0 into two independent 8-bit counters.
// - Timer 1 in mode 3 stops and keeps its count despite its run bit.
// - In modes 0 to 2 both timers run independently.
// - Timer 1 overflows feed the variable serial baud clock.
// - Baud equals 2^double times clock over 32*2*(256-reload byte).
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH

// Register byte offsets.
`define TMR_OFS_CTRL      8'h00
`define TMR_OFS_T0_LOW    8'h04
`define TMR_OFS_T0_HIGH   8'h08
`define TMR_OFS_T1_LOW    8'h0c
`define TMR_OFS_T1_HIGH   8'h10
`define TMR_OFS_STATUS    8'h14
`define TMR_OFS_MASK      8'h18

// Control register fields.
`define TMR_CTRL_RUN0     0
`define TMR_CTRL_RUN1     1
`define TMR_CTRL_MODE0_LO 2
`define TMR_CTRL_MODE0_HI 3
`define TMR_CTRL_MODE1_LO 4
`define TMR_CTRL_MODE1_HI 5
`define TMR_CTRL_EXTSEL   6
`define TMR_CTRL_DOUBLE   7
`define TMR_CTRL_RESET    8'h00

// Status and mask fields.
`define TMR_ST_OVF0       0
`define TMR_ST_OVF1       1
`define TMR_MASK_RESET    2'h0
`define TMR_STATUS_RESET  2'h0

// Modes.
`define TMR_MODE_13BIT    2'h0
`define TMR_MODE_16BIT    2'h1
`define TMR_MODE_RELOAD   2'h2
`define TMR_MODE_SPLIT    2'h3

// Timing counts.
`define TMR_CLKS_PER_MC   2
`define TMR_PRESCALE_MAX  5'h1f
`define TMR_BAUD_DIV      5'h1f
`define TMR_BAUD_DIV_DBL  5'h0f
`define TMR_COUNT_RESET   8'h00

`endif

/* File: rtl/tmr_baud_div.v */
// Baud divider fed by timer 1 overflow pulses.
// Assumes overflow pulses last one clock and reset is synchronous.
`timescale 1ns/1ps
`include "tmr_defines.vh"
module tmr_baud_div (
  // Clock and reset.
  input  wire       core_clk,
  input  wire       reset,
  // Overflow source and rate doubling.
  input  wire       ovfPulse,
  input  wire       doubleSel,
  // One-cycle baud clock pulse.
  output reg        baudTick
);
  reg  [4:0] divCount;
  wire [4:0] divLast;

  // Doubling halves the overflow division from 32 to 16.
  assign divLast = doubleSel ? `TMR_BAUD_DIV_DBL : `TMR_BAUD_DIV;

  // Count overflows and emit one tick per full division.
  always @(posedge core_clk) begin
    if (reset) begin
      divCount <= 5'h00;
      baudTick <= 1'b0;
    end else begin
      baudTick <= 1'b0;
      if (ovfPulse) begin
        if (divCount >= divLast) begin
          divCount <= 5'h00;
          baudTick <= 1'b1;
        end else begin
          divCount <= divCount + 5'h01;
        end
      end
    end
  end
endmodule

/* File: rtl/tmr_dual_timer.v */
// Two count-up timers with four modes each and a baud clock source.
// Assumes a classic Wishbone master on core_clk and a synchronous
// external count input that holds each level for at least one clock.
// Assumes software touches only the low byte of each register, and that
// the serial port takes baudTick as one pulse per bit time.
// The block has no other clock; every slower rate is an enable pulse.
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "tmr_defines.vh"
module tmr_dual_timer (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        reset,
  // Wishbone slave.
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // External count pin for timer 0.
  input  wire        ext_count_input,
  // Interrupt and serial baud clock.
  output reg         irq,
  output wire        baudTick
);
  // Software visible state.
  reg  [7:0] ctrl;
  reg  [7:0] timer0_low_byte;
  reg  [7:0] timer0_high_byte;
  reg  [7:0] timer1_low_byte;
  reg  [7:0] timer1_reload_byte;
  reg  [1:0] status;
  reg  [1:0] mask;

  // Internal timing state.
  reg        mcPhase;
  reg        pinPrev;
  reg        t1OvfPulse;

  // Enables and decoded control fields.
  wire       mcEn;
  wire       pinFall;
  wire       run0;
  wire       run1;
  wire [1:0] mode0;
  wire [1:0] mode1;
  wire       extSel;
  wire       baud_double_select;
  wire       cnt0En;
  wire       cnt1En;
  wire       cnt0HiEn;
  // Bus decode.
  wire       busReq;
  wire       wrLow;
  // Stepper results.
  wire [16:0] step0;
  wire [16:0] step1;
  wire [8:0]  step0Hi;
  // Both timers packed side by side for the stepper loop.
  wire [3:0]  modeAll;
  wire [15:0] lowAll;
  wire [15:0] highAll;
  wire [33:0] stepAll;
  // Flag set and clear terms, one bit per overflow source.
  wire [1:0]  flagSet;
  wire [1:0]  flagClr;
  wire        stWrite;
  wire [1:0]  next_status;

  // Next-state values and overflow strobes.
  reg  [7:0] next_t0Low;
  reg  [7:0] next_t0High;
  reg  [7:0] next_t1Low;
  reg  [7:0] next_t1High;
  reg        ovf0;
  reg        ovf1;
  reg        t1Ovf;
  reg [31:0] readData;

  // Advance one count of a timer in its mode; bit 16 flags the overflow.
  // Mode 0 keeps a five-bit prescaler in the low byte's bottom bits and
  // carries into the high byte; the three bits above the prescaler stay.
  // Mode 1 is a plain 16-bit increment.
  // Mode 2 counts the low byte and refills it from the high byte on wrap.
  // Mode 3 counts the low byte alone; timer 0's high byte is stepped
  // elsewhere, and timer 1 never counts in that mode because it is frozen.
  // Keeping all modes in one function lets both timers share it unchanged.
  function [16:0] stepTimer;
    input [1:0] mode;
    input [7:0] lo;
    input [7:0] hi;
    reg   [16:0] wide;
    begin
      wide = 17'h00000;
      stepTimer = {1'b0, hi, lo};
      case (mode)
        `TMR_MODE_13BIT: begin
          // Low five bits prescale by 32; upper low bits are untouched.
          if (lo[4:0] == `TMR_PRESCALE_MAX) begin
            stepTimer = {(hi == 8'hff), hi + 8'h01, lo[7:5], 5'h00};
          end else begin
            stepTimer = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
          end
        end
        `TMR_MODE_16BIT: begin
          wide = {1'b0, hi, lo} + 17'h00001;
          stepTimer = wide;
        end
        `TMR_MODE_RELOAD: begin
          if (lo == 8'hff) begin
            stepTimer = {1'b1, hi, hi};
          end else begin
            stepTimer = {1'b0, hi, lo + 8'h01};
          end
        end
        default: begin
          // Split mode counts the low byte alone.
          stepTimer = {(lo == 8'hff), hi, lo + 8'h01};
        end
      endcase
    end
  endfunction

  // Control fields; each is a plain slice of the control register, so a
  // mode change takes effect at the very next machine cycle.
  assign run0               = ctrl[`TMR_CTRL_RUN0];
  assign run1               = ctrl[`TMR_CTRL_RUN1];
  assign mode0              = ctrl[`TMR_CTRL_MODE0_HI:`TMR_CTRL_MODE0_LO];
  assign mode1              = ctrl[`TMR_CTRL_MODE1_HI:`TMR_CTRL_MODE1_LO];
  assign extSel             = ctrl[`TMR_CTRL_EXTSEL];
  assign baud_double_select = ctrl[`TMR_CTRL_DOUBLE];

  // Machine cycle enable: one pulse every two clocks. Both timers ride on
  // this single pulse, except timer 0 while it counts pin edges, so they
  // step in the same cycle and no divider per timer is needed.
  always @(posedge core_clk) begin
    if (reset) begin
      mcPhase <= 1'b0;
    end else begin
      mcPhase <= ~mcPhase;
    end
  end
  assign mcEn = mcPhase;

  // Falling edge of the count pin, one pulse per 1-to-0 transition.
  // The previous sample resets high, the pin's idle level, so leaving
  // reset with the pin idle does not produce a false count.
  always @(posedge core_clk) begin
    if (reset) begin
      pinPrev <= 1'b1;
    end else begin
      pinPrev <= ext_count_input;
    end
  end
  assign pinFall = pinPrev & ~ext_count_input;

  // Count enables; timer 1 freezes in split mode whatever its run bit.
  // Pin counting bypasses the machine cycle pulse, so the pin must hold
  // each level for a clock or an edge is missed.
  assign cnt0En   = run0 & (extSel ? pinFall : mcEn);
  assign cnt1En   = run1 & mcEn & (mode1 != `TMR_MODE_SPLIT);
  // In split mode timer 0's high byte runs from timer 1's run bit.
  assign cnt0HiEn = run1 & mcEn & (mode0 == `TMR_MODE_SPLIT);

  // Pack both timers so that one stepper loop serves them both.
  assign modeAll = {mode1, mode0};
  assign lowAll  = {timer1_low_byte, timer0_low_byte};
  assign highAll = {timer1_reload_byte, timer0_high_byte};

  // One stepper per timer; they share the mode rules but no state, so
  // neither timer's count or mode can disturb the other. Split mode is
  // the one place where the two interact, and that is handled below.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : gStep
      assign stepAll[17*ch+16:17*ch] = stepTimer(modeAll[2*ch+1:2*ch],
                                                 lowAll[8*ch+7:8*ch],
                                                 highAll[8*ch+7:8*ch]);
    end
  endgenerate
  assign step0   = stepAll[16:0];
  assign step1   = stepAll[33:17];
  assign step0Hi = {1'b0, timer0_high_byte} + 9'h001;

  // Bus request decode; a write lands in the cycle ack is raised.
  // The request is taken only while ack is low, so a master that keeps
  // its strobe up through the ack cycle does not start a second access.
  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrLow  = busReq & wb_we_i & wb_sel_i[0];

  // Next counter values; a software write wins over a count. Reloading a
  // running timer therefore never leaves it one step past the value that
  // software wrote.
  always @* begin
    next_t0Low  = timer0_low_byte;
    next_t0High = timer0_high_byte;
    next_t1Low  = timer1_low_byte;
    next_t1High = timer1_reload_byte;
    ovf0        = 1'b0;
    ovf1        = 1'b0;
    t1Ovf       = 1'b0;
    // Each timer steps from its own mode and state.
    if (cnt0En) begin
      next_t0Low = step0[7:0];
      ovf0       = step0[16];
      if (mode0 != `TMR_MODE_SPLIT) begin
        next_t0High = step0[15:8];
      end
    end
    // In split mode timer 0's high byte counts on timer 1's run bit.
    if (cnt0HiEn) begin
      next_t0High = step0Hi[7:0];
      ovf1        = step0Hi[8];
    end
    // Timer 1 steps in modes 0 to 2; its overflow also feeds the divider.
    if (cnt1En) begin
      next_t1Low  = step1[7:0];
      next_t1High = step1[15:8];
      t1Ovf       = step1[16];
    end
    // Software writes come last so that they override any count.
    if (wrLow) begin
      if (wb_adr_i == `TMR_OFS_T0_LOW) begin
        next_t0Low = wb_dat_i[7:0];
      end else if (wb_adr_i == `TMR_OFS_T0_HIGH) begin
        next_t0High = wb_dat_i[7:0];
      end else if (wb_adr_i == `TMR_OFS_T1_LOW) begin
        next_t1Low = wb_dat_i[7:0];
      end else if (wb_adr_i == `TMR_OFS_T1_HIGH) begin
        next_t1High = wb_dat_i[7:0];
      end
    end
  end

  // Sticky flags, one per overflow source; write one to clear. Software
  // reads the flags to learn which timer wrapped, so a flag may only fall
  // by its own write. Bit order follows the status field positions.
  assign flagSet = {ovf1 | t1Ovf, ovf0};
  assign stWrite = wrLow & (wb_adr_i == `TMR_OFS_STATUS);
  assign flagClr = stWrite ? wb_dat_i[1:0] : 2'h0;

  // The set term is ORed in last, so an overflow that lands in the same
  // cycle as a clear is kept rather than silently lost.
  genvar fb;
  generate
    for (fb = 0; fb < 2; fb = fb + 1) begin : gFlag
      assign next_status[fb] = (status[fb] & ~flagClr[fb]) | flagSet[fb];
    end
  endgenerate

  // Read multiplexer; unmapped addresses read as zero.
  // Read data is chosen from the address alone and registered by the bus
  // stage only when a request is taken, so it stands until the next access.
  always @* begin
    readData = 32'h00000000;
    if (wb_adr_i == `TMR_OFS_CTRL) begin
      readData = {24'h000000, ctrl};
    end else if (wb_adr_i == `TMR_OFS_T0_LOW) begin
      readData = {24'h000000, timer0_low_byte};
    end else if (wb_adr_i == `TMR_OFS_T0_HIGH) begin
      readData = {24'h000000, timer0_high_byte};
    end else if (wb_adr_i == `TMR_OFS_T1_LOW) begin
      readData = {24'h000000, timer1_low_byte};
    end else if (wb_adr_i == `TMR_OFS_T1_HIGH) begin
      readData = {24'h000000, timer1_reload_byte};
    end else if (wb_adr_i == `TMR_OFS_STATUS) begin
      readData = {30'h0, status};
    end else if (wb_adr_i == `TMR_OFS_MASK) begin
      readData = {30'h0, mask};
    end
  end

  // Counter registers. The combinational block above already resolved
  // writes against counts, so this stage only stores the result and no
  // second priority order can creep in here.
  always @(posedge core_clk) begin
    if (reset) begin
      timer0_low_byte    <= `TMR_COUNT_RESET;
      timer0_high_byte   <= `TMR_COUNT_RESET;
      timer1_low_byte    <= `TMR_COUNT_RESET;
      timer1_reload_byte <= `TMR_COUNT_RESET;
    end else begin
      timer0_low_byte    <= next_t0Low;
      timer0_high_byte   <= next_t0High;
      timer1_low_byte    <= next_t1Low;
      timer1_reload_byte <= next_t1High;
    end
  end

  // Control and mask registers; only the low bits of a write are kept.
  // Both stop all counting and all requests at reset.
  always @(posedge core_clk) begin
    if (reset) begin
      ctrl <= `TMR_CTRL_RESET;
      mask <= `TMR_MASK_RESET;
    end else begin
      if (wrLow && wb_adr_i == `TMR_OFS_CTRL) begin
        ctrl <= wb_dat_i[7:0];
      end
      if (wrLow && wb_adr_i == `TMR_OFS_MASK) begin
        mask <= wb_dat_i[1:0];
      end
    end
  end

  // Bus answer: ack follows one cycle after the strobe and drops the next,
  // and read data is held until the next access.
  always @(posedge core_clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= busReq;
      if (busReq) begin
        wb_dat_o <= readData;
      end
    end
  end

  // Flags, interrupt line and the overflow pulse for the baud divider.
  // The line looks at next_status so that it rises with the flag itself.
  always @(posedge core_clk) begin
    if (reset) begin
      status     <= `TMR_STATUS_RESET;
      irq        <= 1'b0;
      t1OvfPulse <= 1'b0;
    end else begin
      status     <= next_status;
      irq        <= |(next_status & mask);
      t1OvfPulse <= t1Ovf;
    end
  end

  // Timer 1 overflows divided down into the serial baud clock. The pulse
  // is registered on its way in, so each tick trails its overflow by two
  // clocks; the serial side only counts ticks, so the lag does no harm.
  tmr_baud_div tmr_baud_div_inst (
    .core_clk  (core_clk),
    .reset     (reset),
    .ovfPulse  (t1OvfPulse),
    .doubleSel (baud_double_select),
    .baudTick  (baudTick)
  );
endmodule

/* File: verif/tmr_dual_timer_monitor.sv */
// Port assertions for the dual timer: bus handshake, read data, irq, baud.
// Assumes a classic Wishbone master; attached by the bind at the foot.
`timescale 1ns/1ps
module tmr_dual_timer_monitor (
  // Clock and reset.
  input wire        core_clk,
  input wire        reset,
  // Bus.
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // Pin and events.
  input wire        ext_count_input,
  input wire        irq,
  input wire        baudTick
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  reg [7:0] ctrlSeen;
  reg [1:0] maskSeen;
  // Shadow the control and mask registers so that their read data can be judged.
  always @(posedge core_clk) begin
    if (reset) begin
      ctrlSeen <= 8'h00;
      maskSeen <= 2'h0;
    end else if (take && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == 8'h00) ctrlSeen <= wb_dat_i[7:0];
      if (wb_adr_i == 8'h18) maskSeen <= wb_dat_i[1:0];
    end
  end
  a_ack_next: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(take))
    else $error("ack without request");
  a_ctrl_read: assert property (
    take && !wb_we_i && wb_adr_i == 8'h00 |=> wb_dat_o == {24'h0, ctrlSeen})
    else $error("control read data wrong");
  a_mask_read: assert property (
    take && !wb_we_i && wb_adr_i == 8'h18 |=> wb_dat_o == {30'h0, maskSeen})
    else $error("mask read data wrong");
  a_unmapped_zero: assert property (
    take && !wb_we_i && wb_adr_i > 8'h18 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (
    wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_irq_masked: assert property (irq |-> $past(maskSeen) != 2'h0)
    else $error("irq with all sources masked");
  a_baud_gap: assert property (baudTick |=> !baudTick [*8])
    else $error("baud ticks too close");
endmodule
bind tmr_dual_timer tmr_dual_timer_monitor tmr_dual_timer_monitor_inst (
  .core_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_count_input, .irq, .baudTick);

/* File: verif/tmr_dual_timer_tb.sv */
// Self-checking bench for the dual timer: modes, pin count, irq, baud.
// Assumes the design acks one cycle after it takes a bus request.
`timescale 1ns/1ps
module tmr_dual_timer_tb;
  reg         core_clk = 1'b0;
  reg         reset = 1'b1;
  reg         cyc = 1'b0;
  reg         we = 1'b0;
  reg [7:0]   adr = 8'h00;
  reg [31:0]  wdat = 32'h0;
  reg         pin = 1'b1;
  wire [31:0] rdat;
  wire        ack;
  wire        irq;
  wire        tick;
  integer     failures = 0;
  integer     checksDone = 0;
  integer     cycles = 0;
  integer     i;
  integer     t;
  reg [31:0]  got;
  reg [55:0]  r;
  reg [55:0]  rows [0:7];

  tmr_dual_timer tmr_dual_timer_inst (
    .core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ext_count_input(pin), .irq(irq),
    .baudTick(tick));

  always #2 core_clk = ~core_clk;

  // A hang ends the run here instead of stalling forever.
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      test_done;
    end
  end

  task check(input [31:0] seen, input [31:0] exp);
    begin
      checksDone = checksDone + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // One classic cycle, held until ack is sampled, then one idle cycle.
  task wb(input w, input [7:0] a, input [7:0] d);
    begin
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      @(posedge core_clk);
      while (ack !== 1'b1) @(posedge core_clk);
      got = rdat;
      cyc <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  task rd(input [7:0] a, input [7:0] e);
    begin
      wb(1'b0, a, 8'h00);
      check(got, {24'h0, e});
    end
  endtask

  task test_done;
    begin
      $display("checks %0d failures %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  // Rows: ctrl, low address, low, high, increments, expected low, high.
  initial begin
    rows[0] = {8'h01, 8'h04, 8'hfe, 8'h05, 8'h02, 8'he0, 8'h06};
    rows[1] = {8'h05, 8'h04, 8'hfe, 8'h12, 8'h02, 8'h00, 8'h13};
    rows[2] = {8'h09, 8'h04, 8'hfe, 8'h80, 8'h03, 8'h81, 8'h80};
    rows[3] = {8'h0d, 8'h04, 8'hfe, 8'h05, 8'h03, 8'h01, 8'h05};
    rows[4] = {8'h0e, 8'h04, 8'h10, 8'hfe, 8'h03, 8'h10, 8'h01};
    rows[5] = {8'h1b, 8'h0c, 8'hfe, 8'h12, 8'h02, 8'h00, 8'h13};
    rows[6] = {8'h32, 8'h0c, 8'hfe, 8'h12, 8'h04, 8'hfe, 8'h12};
    rows[7] = {8'h04, 8'h04, 8'hfe, 8'h12, 8'h04, 8'hfe, 8'h12};
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(8'h00, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h1c, 8'h00);
    // Run gap between start and stop writes is even, so counts are exact.
    for (i = 0; i < 8; i = i + 1) begin
      r = rows[i];
      wb(1'b1, r[47:40], r[39:32]);
      wb(1'b1, r[47:40] + 8'h04, r[31:24]);
      wb(1'b1, 8'h00, r[55:48]);
      repeat (2 * r[23:16] - 3) @(posedge core_clk);
      wb(1'b1, 8'h00, 8'h00);
      rd(r[47:40], r[15:8]);
      rd(r[47:40] + 8'h04, r[7:0]);
    end
    // Pin edges only; many machine cycles pass meanwhile.
    wb(1'b1, 8'h04, 8'h00);
    wb(1'b1, 8'h00, 8'h45);
    for (i = 0; i < 3; i = i + 1) begin
      pin <= 1'b0;
      repeat (3) @(posedge core_clk);
      pin <= 1'b1;
      repeat (3) @(posedge core_clk);
    end
    wb(1'b1, 8'h00, 8'h00);
    rd(8'h04, 8'h03);
    // Flag, mask and clear.
    wb(1'b1, 8'h14, 8'h03);
    wb(1'b1, 8'h04, 8'hff);
    wb(1'b1, 8'h00, 8'h09);
    wb(1'b1, 8'h00, 8'h00);
    rd(8'h14, 8'h01);
    wb(1'b1, 8'h18, 8'h02);
    check({31'h0, irq}, 32'h0);
    wb(1'b1, 8'h18, 8'h01);
    check({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h14, 8'h01);
    check({31'h0, irq}, 32'h0);
    rd(8'h18, 8'h01);
    // Baud period in clocks is 64 * (256 - reload) / 2^double.
    wb(1'b1, 8'h10, 8'hfe);
    for (i = 0; i < 2; i = i + 1) begin
      wb(1'b1, 8'h00, i ? 8'ha2 : 8'h22);
      while (tick !== 1'b1) @(posedge core_clk);
      t = 1;
      @(posedge core_clk);
      while (tick !== 1'b1) begin
        t = t + 1;
        @(posedge core_clk);
      end
      check(t, 32'd128 >> i);
    end
    // Mid-run reset with timer 1 running and its flag unmasked.
    wb(1'b1, 8'h18, 8'h02);
    check({31'h0, irq}, 32'h1);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    check({31'h0, irq}, 32'h0);
    check({31'h0, tick}, 32'h0);
    rd(8'h00, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h18, 8'h00);
    rd(8'h10, 8'h00);
    test_done;
  end
endmodule
